// file: design/stc_defines.vh
// constants for the sixteen-bit timer/counter block
`ifndef STC_DEFINES_VH
`define STC_DEFINES_VH
// register word indices inside one timer (byte address = 4 * index)
`define STC_IDX_CTRL_A 4'h0
`define STC_IDX_CTRL_B 4'h1
`define STC_IDX_CNT_LO 4'h2
`define STC_IDX_CNT_HI 4'h3
`define STC_IDX_CMPA_LO 4'h4
`define STC_IDX_CMPA_HI 4'h5
`define STC_IDX_CMPB_LO 4'h6
`define STC_IDX_CMPB_HI 4'h7
`define STC_IDX_CAP_LO 4'h8
`define STC_IDX_CAP_HI 4'h9
`define STC_IDX_MASK 4'ha
`define STC_IDX_FLAG 4'hb
`define STC_IDX_LAST 4'hb
// address bit that picks timer 1 or timer 2
`define STC_INST_BIT 6
// control_reg_a fields
`define STC_CA_COMA 7:6
`define STC_CA_COMB 5:4
`define STC_CA_WGM_LO 1:0
`define STC_CA_WMASK 8'hf3
// control_reg_b fields
`define STC_CB_FILT 7
`define STC_CB_EDGE 6
`define STC_CB_ACMP 5
`define STC_CB_WGM_HI 4:3
`define STC_CB_CS 2:0
// flag and mask bit positions
`define STC_F_OVF 0
`define STC_F_CMPA 1
`define STC_F_CMPB 2
`define STC_F_CAP 3
// counter landmarks
`define STC_BOTTOM 16'h0000
`define STC_MAX 16'hffff
`define STC_TOP_8 16'h00ff
`define STC_TOP_9 16'h01ff
`define STC_TOP_10 16'h03ff
// reset values
`define STC_RST_BYTE 8'h00
`define STC_RST_WORD 16'h0000
`define STC_RST_NIB 4'h0
// prescaler taps: divide by 1, 8, 64, 256, 1024
`define STC_PS_W 10
`endif

// file: design/stc_timer.v
// two sixteen-bit timer/counters behind one apb slave
//
// Contract
// RULE_01: 16-bit counter counts up, down or clears on each timer tick.
// RULE_02: counter is two byte locations; low-byte read copies high byte to temp.
// RULE_03: low-byte write loads high byte from temp at once, atomically.
// RULE_04: software reads low then high, writes high then low.
// RULE_05: clock select zero stops counting; counter stays readable and writable.
// RULE_06: software write to counter beats a same-cycle clear or count.
// RULE_07: tick comes from prescaled clock or external pin, picked by clock select.
// RULE_08: bottom indication whenever counter is zero.
// RULE_09: maximum is all ones, 65535.
// RULE_10: top is maximum, fixed value, compare value a or capture value.
// RULE_11: with compare a as pwm top, output a makes no pwm.
// RULE_12: compare values are double buffered in pwm modes.
// RULE_13: both compare values checked continuously; match sets flag, drives output.
// RULE_14: compare flag sets at the tick ending the matching timer cycle.
// RULE_15: capture edge from pin or comparator copies counter into capture value.
// RULE_16: optional filter needs four equal samples before passing a change.
// RULE_17: 4-bit waveform mode split over control registers a and b.
// RULE_18: overflow flag point depends on waveform mode.
// RULE_19: four flags, each masked, feed the interrupt request.
// RULE_20: counter, compares and capture use the temp access procedure.
// RULE_21: control registers a and b are plain bytes, any order.
// RULE_22: two identical timers, each with its own registers.
`timescale 1ns/1ps
`default_nettype none
`include "stc_defines.vh"

module stc_core (
  input wire pclk,
  input wire presetn,
  input wire acc_rd,
  input wire acc_wr,
  input wire [3:0] acc_idx,
  input wire [7:0] acc_wdata,
  output reg [7:0] rd_data,
  input wire [4:0] ps_tick,
  input wire ext_clk_pin,
  input wire capture_input_pin,
  input wire acmp_in,
  output reg compare_output_a,
  output reg compare_output_b,
  output reg timer_irq,
  output reg at_bottom
);
  reg [7:0] control_reg_a_q, control_reg_b_q, temp_q;
  reg [15:0] counter_value_q, cmpa_buf_q, cmpa_q, cmpb_buf_q, cmpb_q, capture_value_q;
  reg [3:0] interrupt_mask_reg_q, interrupt_flag_reg_q;
  reg down_q, block_q;
  reg [1:0] ext_s_q, cap_s_q, acm_s_q;
  reg ext_d_q, cap_lvl_q, cap_d_q;
  reg [3:0] filt_q;
  reg [15:0] cnt_d;
  reg down_d, ovf_ev, wrap_ev, upd_ev, tick;

  // mode decode tables, used for counting, buffering and outputs
  function [1:0] f_top_src; // 0 max, 1 fixed, 2 compare a, 3 capture
    input [3:0] m;
    case (m)
      4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7: f_top_src = 2'h1;
      4'h4, 4'h9, 4'hb, 4'hf: f_top_src = 2'h2;
      4'h8, 4'ha, 4'hc, 4'he: f_top_src = 2'h3;
      default: f_top_src = 2'h0;
    endcase
  endfunction

  function f_updown;
    input [3:0] m;
    f_updown = (m >= 4'h1 && m <= 4'h3) || (m >= 4'h8 && m <= 4'hb);
  endfunction

  function f_pwm;
    input [3:0] m;
    f_pwm = !(m == 4'h0 || m == 4'h4 || m == 4'hc || m == 4'hd);
  endfunction

  // next level of a compare output for one tick
  function f_wave;
    input cur;
    input [1:0] com;
    input match, pwm, ud, down, wrap;
    begin
      f_wave = cur;
      if (!pwm) begin
        if (match)
          f_wave = (com == 2'h1) ? !cur : com[0];
      end else if (ud) begin
        if (match && com[1])
          f_wave = down ? !com[0] : com[0];
      end else if (com[1]) begin
        if (match)
          f_wave = com[0];
        else if (wrap)
          f_wave = !com[0];
      end
    end
  endfunction

  // RULE_17 mode split
  wire [3:0] mode = {control_reg_b_q[`STC_CB_WGM_HI], control_reg_a_q[`STC_CA_WGM_LO]};
  wire [1:0] top_src = f_top_src(mode);
  wire ud = f_updown(mode);
  wire pwm = f_pwm(mode);
  wire [2:0] cs = control_reg_b_q[`STC_CB_CS];
  wire ext_fall = ext_d_q && !ext_s_q[1];
  wire ext_rise = !ext_d_q && ext_s_q[1];

  // RULE_10 top source
  wire [15:0] top_val = (top_src == 2'h2) ? cmpa_q :
                        (top_src == 2'h3) ? capture_value_q :
                        (top_src == 2'h0) ? `STC_MAX :
                        (mode[1:0] == 2'h1) ? `STC_TOP_8 :
                        (mode[1:0] == 2'h2) ? `STC_TOP_9 : `STC_TOP_10;

  wire wr_cnt_lo = acc_wr && acc_idx == `STC_IDX_CNT_LO;
  wire match_a = tick && !block_q && counter_value_q == cmpa_q;
  wire match_b = tick && !block_q && counter_value_q == cmpb_q;

  // tick select and next count; no tick at all when clock select is zero
  always @* begin
    // RULE_05 stopped timer
    // RULE_07 tick source
    case (cs)
      3'h0: tick = 1'b0;
      3'h6: tick = ext_fall;
      3'h7: tick = ext_rise;
      default: tick = ps_tick[cs - 3'h1];
    endcase
    cnt_d = counter_value_q;
    down_d = down_q;
    ovf_ev = 1'b0;
    wrap_ev = 1'b0;
    upd_ev = 1'b0;
    if (tick) begin
      // RULE_01 up, down or clear
      if (ud) begin
        if (!down_q && counter_value_q >= top_val) begin
          down_d = 1'b1;
          cnt_d = counter_value_q - 16'h0001;
          upd_ev = (mode < 4'h8) || (mode > 4'h9);
        end else if (down_q && counter_value_q == `STC_BOTTOM) begin
          down_d = 1'b0;
          cnt_d = counter_value_q + 16'h0001;
          // RULE_18 dual-slope overflow at bottom
          ovf_ev = 1'b1;
          upd_ev = (mode == 4'h8) || (mode == 4'h9);
        end else begin
          cnt_d = down_q ? counter_value_q - 16'h0001 : counter_value_q + 16'h0001;
        end
      end else begin
        down_d = 1'b0;
        wrap_ev = counter_value_q == top_val;
        upd_ev = wrap_ev;
        cnt_d = wrap_ev ? `STC_BOTTOM : counter_value_q + 16'h0001;
        // RULE_09 RULE_18 single-slope overflow at max or at top
        ovf_ev = pwm ? wrap_ev : (counter_value_q == `STC_MAX);
      end
    end
  end

  // capture path: sync, optional filter, edge detect
  wire cap_src = control_reg_b_q[`STC_CB_ACMP] ? acm_s_q[1] : cap_s_q[1];
  wire cap_filt = control_reg_b_q[`STC_CB_FILT] ? cap_lvl_q : cap_src;
  wire cap_edge = (cap_filt != cap_d_q) &&
                  (control_reg_b_q[`STC_CB_EDGE] ? cap_filt : !cap_filt);
  // capture input is off while the capture value serves as top
  wire cap_ev = cap_edge && (top_src != 2'h3);

  // pin synchronisers and capture filter
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_s_q <= 2'h0;
      cap_s_q <= 2'h0;
      acm_s_q <= 2'h0;
      ext_d_q <= 1'b0;
      filt_q <= `STC_RST_NIB;
      cap_lvl_q <= 1'b0;
      cap_d_q <= 1'b0;
    end else begin
      ext_s_q <= {ext_s_q[0], ext_clk_pin};
      cap_s_q <= {cap_s_q[0], capture_input_pin};
      acm_s_q <= {acm_s_q[0], acmp_in};
      ext_d_q <= ext_s_q[1];
      filt_q <= {filt_q[2:0], cap_src};
      // RULE_16 four equal samples
      if (&filt_q)
        cap_lvl_q <= 1'b1;
      else if (~|filt_q)
        cap_lvl_q <= 1'b0;
      cap_d_q <= cap_filt;
    end
  end

  // register file, counter and flags
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_reg_a_q <= `STC_RST_BYTE;
      control_reg_b_q <= `STC_RST_BYTE;
      temp_q <= `STC_RST_BYTE;
      counter_value_q <= `STC_RST_WORD;
      cmpa_buf_q <= `STC_RST_WORD;
      cmpa_q <= `STC_RST_WORD;
      cmpb_buf_q <= `STC_RST_WORD;
      cmpb_q <= `STC_RST_WORD;
      capture_value_q <= `STC_RST_WORD;
      interrupt_mask_reg_q <= `STC_RST_NIB;
      interrupt_flag_reg_q <= `STC_RST_NIB;
      down_q <= 1'b0;
      block_q <= 1'b0;
    end else begin
      // RULE_06 write beats count
      // RULE_03 atomic 16-bit load
      if (wr_cnt_lo) begin
        counter_value_q <= {temp_q, acc_wdata};
        down_q <= down_d;
      end else begin
        counter_value_q <= cnt_d;
        down_q <= down_d;
      end
      // a counter write hides the compare on the next tick
      if (wr_cnt_lo)
        block_q <= 1'b1;
      else if (tick)
        block_q <= 1'b0;
      // RULE_12 buffered compare values move at the update point
      if (!pwm || upd_ev) begin
        cmpa_q <= cmpa_buf_q;
        cmpb_q <= cmpb_buf_q;
      end
      // RULE_15 capture copies the counter
      if (cap_ev)
        capture_value_q <= counter_value_q;
      // RULE_13 RULE_14 RULE_19 flags: hardware set wins over write-one clear
      interrupt_flag_reg_q <= (interrupt_flag_reg_q &
        ~((acc_wr && acc_idx == `STC_IDX_FLAG) ? acc_wdata[3:0] : 4'h0)) |
        {cap_ev, match_b, match_a, ovf_ev};
      if (acc_wr) begin
        case (acc_idx)
          // RULE_21 plain control bytes
          `STC_IDX_CTRL_A: control_reg_a_q <= acc_wdata & `STC_CA_WMASK;
          `STC_IDX_CTRL_B: control_reg_b_q <= acc_wdata;
          `STC_IDX_CMPA_LO: cmpa_buf_q <= {temp_q, acc_wdata};
          `STC_IDX_CMPB_LO: cmpb_buf_q <= {temp_q, acc_wdata};
          `STC_IDX_CAP_LO: begin
            // capture value is writable only while it serves as top
            if (top_src == 2'h3)
              capture_value_q <= {temp_q, acc_wdata};
          end
          `STC_IDX_MASK: interrupt_mask_reg_q <= acc_wdata[3:0];
          // RULE_20 high bytes go to temp
          `STC_IDX_CNT_HI, `STC_IDX_CMPA_HI, `STC_IDX_CMPB_HI, `STC_IDX_CAP_HI:
            temp_q <= acc_wdata;
          default: ;
        endcase
      end
      // RULE_02 low-byte read snapshots the high byte; last so it wins
      if (acc_rd) begin
        case (acc_idx)
          `STC_IDX_CNT_LO: temp_q <= counter_value_q[15:8];
          `STC_IDX_CMPA_LO: temp_q <= cmpa_buf_q[15:8];
          `STC_IDX_CMPB_LO: temp_q <= cmpb_buf_q[15:8];
          `STC_IDX_CAP_LO: temp_q <= capture_value_q[15:8];
          default: ;
        endcase
      end
    end
  end

  // outputs: waveforms, interrupt request, bottom indication
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_output_a <= 1'b0;
      compare_output_b <= 1'b0;
      timer_irq <= 1'b0;
      at_bottom <= 1'b1;
    end else begin
      // RULE_11 no pwm on a when a sets the top
      if (tick && !(pwm && top_src == 2'h2))
        compare_output_a <= f_wave(compare_output_a, control_reg_a_q[`STC_CA_COMA],
                                   match_a, pwm, ud, down_q, wrap_ev);
      // RULE_13 match drives output b
      if (tick)
        compare_output_b <= f_wave(compare_output_b, control_reg_a_q[`STC_CA_COMB],
                                   match_b, pwm, ud, down_q, wrap_ev);
      // RULE_19 masked request
      timer_irq <= |(interrupt_flag_reg_q & interrupt_mask_reg_q);
      // RULE_08 bottom indication
      at_bottom <= (wr_cnt_lo ? {temp_q, acc_wdata} : cnt_d) == `STC_BOTTOM;
    end
  end

  // read mux; high locations always show temp
  always @* begin
    case (acc_idx)
      `STC_IDX_CTRL_A: rd_data = control_reg_a_q;
      `STC_IDX_CTRL_B: rd_data = control_reg_b_q;
      `STC_IDX_CNT_LO: rd_data = counter_value_q[7:0];
      `STC_IDX_CMPA_LO: rd_data = cmpa_buf_q[7:0];
      `STC_IDX_CMPB_LO: rd_data = cmpb_buf_q[7:0];
      `STC_IDX_CAP_LO: rd_data = capture_value_q[7:0];
      `STC_IDX_MASK: rd_data = {4'h0, interrupt_mask_reg_q};
      `STC_IDX_FLAG: rd_data = {4'h0, interrupt_flag_reg_q};
      `STC_IDX_CNT_HI, `STC_IDX_CMPA_HI, `STC_IDX_CMPB_HI, `STC_IDX_CAP_HI:
        rd_data = temp_q;
      default: rd_data = 8'h00;
    endcase
  end
endmodule // stc_core

module stc_timer (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [1:0] ext_clk_pin,
  input wire [1:0] capture_input_pin,
  input wire [1:0] acmp_in,
  output wire [1:0] compare_output_a,
  output wire [1:0] compare_output_b,
  output wire [1:0] timer_irq,
  output wire [1:0] at_bottom
);
  reg [`STC_PS_W-1:0] ps_q;
  wire [7:0] rd0, rd1;
  wire [15:0] rd_all;
  wire [3:0] idx = paddr[5:2];
  wire inst = paddr[`STC_INST_BIT];
  // word aligned, inside the map, no stray upper bits
  wire hit = (paddr[1:0] == 2'h0) && (paddr[11:7] == 5'h00) && (idx <= `STC_IDX_LAST);
  wire setup = psel && !penable;
  wire done = psel && penable && pready;
  wire rd_stb = setup && !pwrite && hit;
  wire wr_stb = done && pwrite && !pslverr;
  // shared free-running prescaler taps: 1, 8, 64, 256, 1024
  wire [4:0] ps_tick = {&ps_q[9:0], &ps_q[7:0], &ps_q[5:0], &ps_q[2:0], 1'b1};

  // apb slave: answer in the first access cycle, read data taken at setup
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      ps_q <= {`STC_PS_W{1'b0}};
    end else begin
      ps_q <= ps_q + {{(`STC_PS_W-1){1'b0}}, 1'b1};
      pready <= setup;
      if (setup) begin
        pslverr <= !hit;
        prdata <= (pwrite || !hit) ? 32'h00000000 : {24'h000000, inst ? rd1 : rd0};
      end
    end
  end

  // RULE_22 two identical timers
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_tmr
      stc_core u_core (
        .pclk(pclk),
        .presetn(presetn),
        .acc_rd(rd_stb && (inst == (g != 0))),
        .acc_wr(wr_stb && (inst == (g != 0))),
        .acc_idx(idx),
        .acc_wdata(pwdata[7:0]),
        .rd_data(rd_all[g*8 +: 8]),
        .ps_tick(ps_tick),
        .ext_clk_pin(ext_clk_pin[g]),
        .capture_input_pin(capture_input_pin[g]),
        .acmp_in(acmp_in[g]),
        .compare_output_a(compare_output_a[g]),
        .compare_output_b(compare_output_b[g]),
        .timer_irq(timer_irq[g]),
        .at_bottom(at_bottom[g])
      );
    end
  endgenerate
  // per-timer read bytes, picked by the instance bit at setup
  assign rd0 = rd_all[7:0];
  assign rd1 = rd_all[15:8];
endmodule // stc_timer
`default_nettype wire

// file: design/stc_timer_unused_guard.v
// empty unit beside the timer design; it holds no logic
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// file: bench/stc_timer_sva.sv
// bus and status checks for the dual timer block
`timescale 1ns/1ps
`default_nettype none
module stc_timer_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [1:0] timer_irq,
  input wire logic [1:0] at_bottom
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic setup = psel && !penable;
  wire logic mapped = paddr[1:0] == 2'b00 && paddr[5:2] <= 4'hb && paddr[11:7] == 5'h00;
  property p_rdy_next; setup |=> pready && penable; endproperty
  a_rdy_next: assert property (p_rdy_next) else $error("no ready after setup");
  property p_rdy_pulse; pready |=> !pready; endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready too long");
  property p_rdy_acc; pready |-> psel && penable; endproperty
  a_rdy_acc: assert property (p_rdy_acc) else $error("ready outside access");
  property p_err_map; setup && !mapped |=> pslverr; endproperty
  a_err_map: assert property (p_err_map) else $error("unmapped not refused");
  property p_ok_map; setup && mapped |=> !pslverr; endproperty
  a_ok_map: assert property (p_ok_map) else $error("mapped refused");
  property p_err_rd0; pready && pslverr && !pwrite |-> prdata == 32'h0; endproperty
  a_err_rd0: assert property (p_err_rd0) else $error("refused read not zero");
  property p_hi_zero; pready |-> prdata[31:8] == 24'h0; endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("upper read bits set");
  property p_bot_rst; $rose(presetn) |-> at_bottom == 2'b11; endproperty
  a_bot_rst: assert property (p_bot_rst) else $error("bottom low after reset");
  c_write: cover property (pready && pwrite);
  c_err: cover property (pready && pslverr);
  c_irq: cover property ($rose(timer_irq[0]));
endmodule // stc_timer_sva
`default_nettype wire

// file: bench/stc_cpu_model.sv
// cpu side model: byte transfers over apb with sixteen-bit pairing
`timescale 1ns/1ps
`default_nettype none
module stc_cpu_model (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic hung
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    hung = 1'b0;
  end
  // request held until ready is seen at a rising edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
                      output logic [7:0] q, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    q = prdata[7:0];
    e = pslverr;
    if (n >= 40) hung = 1'b1;
    // released lines must not keep their old value
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~pwdata;
  endtask
  task automatic rd16(input logic [11:0] a, output logic [15:0] v);
    logic e;
    xfer(1'b0, a, 8'h00, v[7:0], e);
    xfer(1'b0, a + 12'h4, 8'h00, v[15:8], e);
  endtask
  task automatic wr16(input logic [11:0] a, input logic [15:0] v);
    logic [7:0] q;
    logic e;
    xfer(1'b1, a + 12'h4, v[15:8], q, e);
    xfer(1'b1, a, v[7:0], q, e);
  endtask
endmodule // stc_cpu_model
`default_nettype wire

// file: bench/testbench.sv
// self-checking bench for the dual sixteen-bit timer block
`timescale 1ns/1ps
`default_nettype none
`include "stc_defines.vh"
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, hung, tm;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0] ext_pin, cap_pin, acmp, out_a, out_b, irq, bot;
  logic [15:0] v, c;
  logic [7:0] q;
  logic e;
  int fails = 0;
  int n_checks = 0;
  always #2.5 pclk = ~pclk;
  stc_cpu_model u_cpu (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hung(hung));
  stc_timer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_clk_pin(ext_pin), .capture_input_pin(cap_pin),
    .acmp_in(acmp), .compare_output_a(out_a), .compare_output_b(out_b),
    .timer_irq(irq), .at_bottom(bot));
  task automatic results;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // a stuck bus ends the run at once
  always @(posedge hung) begin
    fails++;
    results;
  end
  task automatic chk8(input logic [7:0] g, input logic [7:0] x);
    n_checks++;
    if (g !== x) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, g, x);
    end
  endtask
  task automatic chk1(input logic g, input logic x);
    chk8({7'h0, g}, {7'h0, x});
  endtask
  function automatic logic [11:0] ad(input logic [3:0] i);
    return {5'h0, tm, i, 2'b00};
  endfunction
  task automatic wr(input logic [3:0] i, input logic [7:0] d);
    u_cpu.xfer(1'b1, ad(i), d, q, e);
  endtask
  task automatic rd(input logic [3:0] i);
    u_cpu.xfer(1'b0, ad(i), 8'h00, q, e);
  endtask
  task automatic wait_irq(input int lim);
    int n;
    n = 0;
    while (irq[tm] !== 1'b1 && n < lim) begin
      @(posedge pclk);
      n++;
    end
    chk1(n < lim, 1'b1);
  endtask
  task automatic t_ctrl;
    wr(`STC_IDX_CTRL_A, 8'hff);
    wr(`STC_IDX_CTRL_B, 8'h18);
    rd(`STC_IDX_CTRL_A);
    chk8(q, `STC_CA_WMASK);
    rd(`STC_IDX_CTRL_B);
    chk8(q, 8'h18);
    wr(`STC_IDX_CTRL_A, 8'h00);
    wr(`STC_IDX_CTRL_B, 8'h00);
  endtask
  task automatic t_cnt;
    u_cpu.wr16(ad(`STC_IDX_CNT_LO), 16'h1234);
    repeat (5) @(posedge pclk);
    chk1(bot[tm], 1'b0);
    u_cpu.rd16(ad(`STC_IDX_CNT_LO), v);
    chk8(v[15:8], 8'h12);
    chk8(v[7:0], 8'h34);
    u_cpu.wr16(ad(`STC_IDX_CNT_LO), 16'h0000);
    @(posedge pclk);
    chk1(bot[tm], 1'b1);
  endtask
  // low byte read while the high byte rolls over
  task automatic t_snap;
    // start close enough that the high byte rolls between the two reads
    u_cpu.wr16(ad(`STC_IDX_CNT_LO), 16'h00fd);
    wr(`STC_IDX_CTRL_B, 8'h01);
    u_cpu.rd16(ad(`STC_IDX_CNT_LO), v);
    wr(`STC_IDX_CTRL_B, 8'h00);
    chk8(v[15:8], (v[7:0] >= 8'hf2) ? 8'h00 : 8'h01);
  endtask
  task automatic t_ovf;
    wr(`STC_IDX_MASK, 8'h00);
    u_cpu.wr16(ad(`STC_IDX_CNT_LO), 16'hfffd);
    wr(`STC_IDX_CTRL_B, 8'h01);
    repeat (20) @(posedge pclk);
    chk1(irq[tm], 1'b0);
    wr(`STC_IDX_CTRL_B, 8'h00);
    rd(`STC_IDX_FLAG);
    chk1(q[`STC_F_OVF], 1'b1);
    u_cpu.rd16(ad(`STC_IDX_CNT_LO), v);
    chk8(v[15:8], 8'h00);
    wr(`STC_IDX_MASK, 8'h01);
    wait_irq(10);
    wr(`STC_IDX_FLAG, 8'h0f);
    repeat (3) @(posedge pclk);
    chk1(irq[tm], 1'b0);
  endtask
  task automatic t_cmp;
    u_cpu.wr16(ad(`STC_IDX_CMPA_LO), 16'h0030);
    u_cpu.wr16(ad(`STC_IDX_CMPB_LO), 16'h0050);
    u_cpu.wr16(ad(`STC_IDX_CNT_LO), 16'h0000);
    wr(`STC_IDX_FLAG, 8'h0f);
    wr(`STC_IDX_MASK, 8'h02);
    // output a toggles and output b sets on their matches
    wr(`STC_IDX_CTRL_A, 8'h70);
    wr(`STC_IDX_CTRL_B, 8'h01);
    wait_irq(200);
    chk1(out_a[tm], 1'b1);
    chk1(out_b[tm], 1'b0);
    u_cpu.rd16(ad(`STC_IDX_CNT_LO), v);
    chk1(v > 16'h0030 && v < 16'h0050, 1'b1);
    // drop flag a first so the old request cannot end the next wait
    wr(`STC_IDX_FLAG, 8'h02);
    wr(`STC_IDX_MASK, 8'h04);
    wait_irq(200);
    chk1(out_b[tm], 1'b1);
    wr(`STC_IDX_CTRL_B, 8'h00);
    wr(`STC_IDX_CTRL_A, 8'h00);
    wr(`STC_IDX_FLAG, 8'h0f);
  endtask
  task automatic t_cap;
    wr(`STC_IDX_MASK, 8'h08);
    wr(`STC_IDX_CTRL_B, 8'hc1);
    // a two-cycle glitch must die in the filter
    cap_pin[tm] <= 1'b1;
    repeat (2) @(posedge pclk);
    cap_pin[tm] <= 1'b0;
    repeat (20) @(posedge pclk);
    chk1(irq[tm], 1'b0);
    cap_pin[tm] <= 1'b1;
    wait_irq(30);
    // keep rising edge selected so the pin release captures nothing
    wr(`STC_IDX_CTRL_B, 8'h40);
    cap_pin[tm] <= 1'b0;
    u_cpu.rd16(ad(`STC_IDX_CAP_LO), c);
    u_cpu.rd16(ad(`STC_IDX_CNT_LO), v);
    chk1(c != 16'h0 && c < v, 1'b1);
    u_cpu.wr16(ad(`STC_IDX_CAP_LO), 16'hffff);
    u_cpu.rd16(ad(`STC_IDX_CAP_LO), v);
    chk8(v[7:0], c[7:0]);
    wr(`STC_IDX_FLAG, 8'h0f);
  endtask
  task automatic t_err;
    u_cpu.xfer(1'b0, ad(4'hc), 8'h00, q, e);
    chk1(e, 1'b1);
    u_cpu.xfer(1'b1, ad(`STC_IDX_MASK) | 12'h001, 8'h0f, q, e);
    chk1(e, 1'b1);
    // the refused write must leave the mask as it was
    rd(`STC_IDX_MASK);
    chk8(q, 8'h08);
  endtask
  // second timer counts pin pulses; the first one keeps its value
  task automatic t_ext;
    u_cpu.wr16(ad(`STC_IDX_CNT_LO), 16'h0abc);
    tm = 1'b1;
    for (int cs = 6; cs < 8; cs++) begin
      u_cpu.wr16(ad(`STC_IDX_CNT_LO), 16'h0000);
      wr(`STC_IDX_CTRL_B, cs[7:0]);
      repeat (3) begin
        ext_pin[1] <= 1'b1;
        repeat (6) @(posedge pclk);
        ext_pin[1] <= 1'b0;
        repeat (6) @(posedge pclk);
      end
      wr(`STC_IDX_CTRL_B, 8'h00);
      u_cpu.rd16(ad(`STC_IDX_CNT_LO), v);
      chk8(v[7:0], 8'h03);
    end
    tm = 1'b0;
    u_cpu.rd16(ad(`STC_IDX_CNT_LO), v);
    chk8(v[11:4], 8'hab);
  endtask
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    tm = 1'b0;
    ext_pin = 2'b00;
    cap_pin = 2'b00;
    acmp = 2'b00;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_ctrl;
    t_cnt;
    t_snap;
    t_ovf;
    t_cmp;
    t_cap;
    t_err;
    t_ext;
    results;
  end
endmodule // testbench
bind stc_timer stc_timer_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .timer_irq(timer_irq), .at_bottom(at_bottom));
`default_nettype wire
